// ==== include/wits_framer_params.svh ====
// Constants for the packet framer: register map, reset values, characters, item codes and timing
`ifndef WITS_FRAMER_PARAMS_SVH
`define WITS_FRAMER_PARAMS_SVH

`define CLK_HZ 125_000_000
`define REC_PERIOD_S 6
`define REC_PERIOD_CYCLES (`REC_PERIOD_S * `CLK_HZ)
`define BAUD_RATE 9_600
`define CLKS_PER_BIT ((`CLK_HZ + (`BAUD_RATE / 2)) / `BAUD_RATE)
`define UART_FRAME_BITS 10
`define LOCK_NULLS 3

`define REG_GAS_EN 8'h0C
`define REG_GAS_DIV 8'h1A
`define REG_HS_SEL 8'h43
`define REG_UNITS 8'h44
`define REG_HOST_MASK 8'h46
`define REG_STATUS 8'h47

`define RST_GAS_EN 16'h0001
`define RST_GAS_DIV 16'h0001
`define RST_HS_SEL 16'h0000
`define RST_UNITS 16'h0000
`define RST_HOST_MASK 16'h00FF

`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_COMMA 8'h2C
`define CH_AMP 8'h26
`define CH_BANG 8'h21
`define CH_CARET 8'h5E
`define CH_MINUS 8'h2D
`define CH_DOT 8'h2E
`define CH_SLASH 8'h2F
`define CH_COLON 8'h3A
`define DIGIT_HI 4'h3

`define ID_NULL 16'h0111
`define NULL_VALUE 32'hFFFF_D8F1
`define ID_TOTAL_GAS 16'h0140
`define ID_C1 16'h1212
`define ID_CO2 16'h1222
`define ID_O2 16'h1225
`define ID_H2S 16'h1826
`define ID_LAG_STROKES 16'h0138
`define ID_LAG_DEPTH 16'h0139
`define REC_ITEMS 5'h0D
`define HDR_LEN 6'h1F
`define DEC_DIGITS 10

`endif

// ==== include/wits_framer_pkg.sv ====
// Types shared by the packet framer modules
package wits_framer_pkg;

  typedef logic signed [31:0] value_type;

  // Gas index 0 is total gas, 1 to 7 are C1 to NC5
  typedef struct packed {
    value_type [7:0] gas_units;
    value_type [7:0] gas_ppm;
    value_type co2;
    value_type o2;
    value_type h2s;
    value_type lag_strokes;
    value_type lag_depth;
  } meas_type;

  // All fields are BCD
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } stamp_type;

  typedef struct packed {
    logic [15:0] id;
    logic two_dec;
    logic divide;
    value_type value;
  } item_type;

  typedef enum logic [1:0] {
    KIND_NULL = 2'h0,
    KIND_DATA = 2'h1,
    KIND_HOST = 2'h2
  } frame_kind_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LIT = 6'h02,
    ST_ITEMS = 6'h04,
    ST_CONV = 6'h08,
    ST_WAIT = 6'h10,
    ST_DIGITS = 6'h20
  } eng_state_type;

  typedef enum logic [2:0] {
    CV_IDLE = 3'h1,
    CV_DIV = 3'h2,
    CV_BCD = 3'h4
  } conv_state_type;

endpackage : wits_framer_pkg

// ==== design/serial_tx.sv ====
// Asynchronous serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`include "wits_framer_params.svh"
module serial_tx import wits_framer_pkg::*; #(
  parameter int unsigned CLKS_PER_BIT = `CLKS_PER_BIT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic txd
);
  logic [9:0] shift_q;
  logic [3:0] bits_q;
  logic [31:0] baud_q;
  logic busy_q;

  assign tx_ready = ~busy_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_q <= 10'h3FF;
      bits_q <= 4'h0;
      baud_q <= 32'h0000_0000;
      busy_q <= 1'b0;
      txd <= 1'b1;
    end else if (!busy_q) begin
      txd <= 1'b1;
      if (tx_valid) begin
        // Start bit low, data LSB first, stop bit high
        shift_q <= {1'b1, tx_byte, 1'b0};
        bits_q <= 4'(`UART_FRAME_BITS);
        baud_q <= 32'h0000_0000;
        busy_q <= 1'b1;
      end
    end else begin
      txd <= shift_q[0];
      if (baud_q == CLKS_PER_BIT - 1) begin
        baud_q <= 32'h0000_0000;
        shift_q <= {1'b1, shift_q[9:1]};
        bits_q <= bits_q - 4'h1;
        if (bits_q == 4'h1) begin
          busy_q <= 1'b0;
        end
      end else begin
        baud_q <= baud_q + 32'h0000_0001;
      end
    end
  end
endmodule : serial_tx

// ==== design/value_to_decimal.sv ====
// Sequential divider followed by binary to BCD conversion
`timescale 1ns/1ps
`include "wits_framer_params.svh"
module value_to_decimal import wits_framer_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  output logic valid,
  output logic [39:0] bcd
);
  conv_state_type state_q;
  logic [31:0] quot_q;
  logic [15:0] rem_q;
  logic [15:0] div_q;
  logic [4:0] cnt_q;
  logic [16:0] trial;
  logic [39:0] adj;

  assign trial = {1'b0, rem_q[14:0], quot_q[31]} | {rem_q[15], 16'h0000};

  // Add three to every nibble at five or above before each shift
  for (genvar g = 0; g < `DEC_DIGITS; g++) begin : g_adj
    assign adj[4*g +: 4] = (bcd[4*g +: 4] >= 4'h5) ? bcd[4*g +: 4] + 4'h3 : bcd[4*g +: 4];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= CV_IDLE;
      quot_q <= 32'h0000_0000;
      rem_q <= 16'h0000;
      div_q <= 16'h0001;
      cnt_q <= 5'h00;
      bcd <= 40'h00_0000_0000;
      valid <= 1'b0;
    end else begin
      case (state_q)
        CV_IDLE: begin
          if (start) begin
            quot_q <= dividend;
            div_q <= divisor;
            rem_q <= 16'h0000;
            cnt_q <= 5'h00;
            valid <= 1'b0;
            state_q <= CV_DIV;
          end
        end
        CV_DIV: begin
          if (trial >= {1'b0, div_q}) begin
            rem_q <= 16'(trial - {1'b0, div_q});
            quot_q <= {quot_q[30:0], 1'b1};
          end else begin
            rem_q <= trial[15:0];
            quot_q <= {quot_q[30:0], 1'b0};
          end
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h1F) begin
            bcd <= 40'h00_0000_0000;
            state_q <= CV_BCD;
          end
        end
        CV_BCD: begin
          bcd <= {adj[38:0], quot_q[31]};
          quot_q <= {quot_q[30:0], 1'b0};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h1F) begin
            valid <= 1'b1;
            state_q <= CV_IDLE;
          end
        end
        default: begin
          state_q <= CV_IDLE;
        end
      endcase
    end
  end
endmodule : value_to_decimal

// ==== design/wits_packet_framer.sv ====
// Builds host text packets and periodic recorder packets from measurement items
// Operation
// - Host packet starts with caret, job id, date, time, packet number, then items.
// - Host packet number equals the main instrument packet sequence number.
// - Every host packet ends with carriage return then line feed.
// - Host header fields and items are separated by commas.
// - Item is four-digit identifier immediately followed by decimal value text.
// - Host item count follows configuration, not fixed.
// - One recorder transmission every six seconds.
// - Recorder link is asynchronous 9600 baud, 8 data bits, no parity, one stop.
// - Handshake select zero sends null keep-alive packets.
// - Gas enabled sends gas only after null packets established the link; the code also sends gas at once while handshake select is nonzero.
// - Gas disabled sends only null packets.
// - Recorder items go out in fixed order 0140, 1212-1218, 1222, 1225, 1826, 0138, 0139.
// - Total gas item is total gas divided by divisor register.
// - Unit register picks gas units or ppm for total and component gases.
// - Lag strokes and lag depth only when a PC is connected.
// - Recorder transmission opens with && and closes with !!.
// - Communication starts automatically with no operator action.
// - Null packet is &&, 0111-9999, !!, each line ending in carriage return.
// - Null packets repeat until the recorder locks onto the link format.
// - After lock, either data packets or null packets keep the link alive.
`timescale 1ns/1ps
`include "wits_framer_params.svh"
module wits_packet_framer import wits_framer_pkg::*; #(
  parameter int unsigned PERIOD_CYCLES = `REC_PERIOD_CYCLES,
  parameter int unsigned CLKS_PER_BIT = `CLKS_PER_BIT,
  parameter int unsigned LOCK_NULLS = `LOCK_NULLS,
  parameter int unsigned N_HOST = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire meas_type meas,
  input wire logic pc_connected,
  input wire logic host_send,
  input wire logic [31:0] packet_number,
  input wire logic [63:0] job_id,
  input wire stamp_type stamp,
  input wire item_type [N_HOST-1:0] host_items,
  input wire logic host_ready,
  output logic [7:0] host_data,
  output logic host_valid,
  output logic txd
);
  logic [15:0] gas_en_q;
  logic [15:0] gas_div_q;
  logic [15:0] hs_sel_q;
  logic [15:0] units_q;
  logic [15:0] host_mask_q;
  logic pc_meta_q;
  logic pc_sync_q;
  logic [31:0] tmr_q;
  logic rec_pend_q;
  logic host_pend_q;
  logic [7:0] null_cnt_q;
  logic locked;
  eng_state_type state_q;
  eng_state_type after_q;
  frame_kind_type kind_q;
  logic [255:0] lit_q;
  logic [5:0] lit_n_q;
  logic [4:0] idx_q;
  logic [4:0] item_cnt;
  logic [31:0] conv_mag_q;
  logic [15:0] conv_div_q;
  logic neg_q;
  logic two_dec_q;
  logic dot_q;
  logic [3:0] pos_q;
  logic [3:0] start_pos;
  logic conv_valid;
  logic [39:0] conv_bcd;
  logic uart_ready;
  logic rec_valid_q;
  logic [7:0] rec_byte_q;
  logic free;
  logic rec_tick;
  logic start_rec;
  logic start_host;
  item_type it;
  logic it_ok;
  value_type [7:0] gas_sel;
  logic [247:0] hdr;

  assign locked = (null_cnt_q >= 8'(LOCK_NULLS));
  assign free = ~host_valid & ~rec_valid_q;
  assign rec_tick = (tmr_q == PERIOD_CYCLES - 1);
  assign start_rec = (state_q == ST_IDLE) && rec_pend_q;
  assign start_host = (state_q == ST_IDLE) && !rec_pend_q && host_pend_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gas_en_q <= `RST_GAS_EN;
      gas_div_q <= `RST_GAS_DIV;
      hs_sel_q <= `RST_HS_SEL;
      units_q <= `RST_UNITS;
      host_mask_q <= `RST_HOST_MASK;
    end else if (wr) begin
      case (addr)
        `REG_GAS_EN: gas_en_q <= wdata;
        `REG_GAS_DIV: gas_div_q <= wdata;
        `REG_HS_SEL: hs_sel_q <= wdata;
        `REG_UNITS: units_q <= wdata;
        `REG_HOST_MASK: host_mask_q <= wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `REG_GAS_EN: rdata <= gas_en_q;
        `REG_GAS_DIV: rdata <= gas_div_q;
        `REG_HS_SEL: rdata <= hs_sel_q;
        `REG_UNITS: rdata <= units_q;
        `REG_HOST_MASK: rdata <= host_mask_q;
        `REG_STATUS: rdata <= {13'h0000, (state_q != ST_IDLE), pc_sync_q, locked};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PC presence pin synchroniser

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc_meta_q <= 1'b0;
      pc_sync_q <= 1'b0;
    end else begin
      pc_meta_q <= pc_connected;
      pc_sync_q <= pc_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Recorder period and pending requests

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_q <= 32'h0000_0000;
    end else if (rec_tick) begin
      tmr_q <= 32'h0000_0000;
    end else begin
      tmr_q <= tmr_q + 32'h0000_0001;
    end
  end

  // Pending after reset so the link is brought up unattended
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rec_pend_q <= 1'b1;
      host_pend_q <= 1'b0;
    end else begin
      rec_pend_q <= rec_tick | (rec_pend_q & ~start_rec);
      host_pend_q <= host_send | (host_pend_q & ~start_host);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Item selection

  // Header: caret, job id, date, time, each followed by a comma
  assign hdr = {`CH_CARET, `CH_COMMA, job_id, `CH_COMMA,
    `DIGIT_HI, stamp.year[15:12], `DIGIT_HI, stamp.year[11:8],
    `DIGIT_HI, stamp.year[7:4], `DIGIT_HI, stamp.year[3:0], `CH_SLASH,
    `DIGIT_HI, stamp.month[7:4], `DIGIT_HI, stamp.month[3:0], `CH_SLASH,
    `DIGIT_HI, stamp.day[7:4], `DIGIT_HI, stamp.day[3:0], `CH_COMMA,
    `DIGIT_HI, stamp.hour[7:4], `DIGIT_HI, stamp.hour[3:0], `CH_COLON,
    `DIGIT_HI, stamp.minute[7:4], `DIGIT_HI, stamp.minute[3:0], `CH_COLON,
    `DIGIT_HI, stamp.second[7:4], `DIGIT_HI, stamp.second[3:0], `CH_COMMA};

  assign gas_sel = (units_q != 16'h0000) ? meas.gas_ppm : meas.gas_units;

  always_comb begin
    it = '0;
    it_ok = 1'b0;
    item_cnt = 5'h01;
    case (kind_q)
      KIND_NULL: begin
        it.id = `ID_NULL;
        it.value = `NULL_VALUE;
        it_ok = 1'b1;
      end
      KIND_DATA: begin
        item_cnt = `REC_ITEMS;
        it_ok = 1'b1;
        it.two_dec = 1'b1;
        // Fixed recorder order
        if (idx_q < 5'h08) begin
          it.id = (idx_q == 5'h00) ? `ID_TOTAL_GAS : `ID_C1 + 16'(idx_q - 5'h01);
          it.value = gas_sel[idx_q[2:0]];
          it.divide = (idx_q == 5'h00);
        end else begin
          case (idx_q)
            5'h08: begin
              it.id = `ID_CO2;
              it.value = meas.co2;
            end
            5'h09: begin
              it.id = `ID_O2;
              it.value = meas.o2;
            end
            5'h0A: begin
              it.id = `ID_H2S;
              it.value = meas.h2s;
            end
            5'h0B: begin
              it.id = `ID_LAG_STROKES;
              it.value = meas.lag_strokes;
              it.two_dec = 1'b0;
              it_ok = pc_sync_q;
            end
            5'h0C: begin
              it.id = `ID_LAG_DEPTH;
              it.value = meas.lag_depth;
              it.two_dec = 1'b0;
              it_ok = pc_sync_q;
            end
            default: it_ok = 1'b0;
          endcase
        end
      end
      KIND_HOST: begin
        item_cnt = 5'(N_HOST);
        // Configured subset of host items
        if (idx_q < 5'(N_HOST)) begin
          it = host_items[idx_q];
          it.divide = 1'b0;
          it_ok = host_mask_q[idx_q[3:0]];
        end
      end
      default: begin
      end
    endcase
  end

  // Leading zeros suppressed, at least one integer digit
  always_comb begin
    start_pos = two_dec_q ? 4'h2 : 4'h0;
    for (int i = 0; i < `DEC_DIGITS; i++) begin
      if (conv_bcd[4*i +: 4] != 4'h0 && 4'(i) > start_pos) begin
        start_pos = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame engine

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      kind_q <= KIND_NULL;
      lit_q <= 256'h0;
      lit_n_q <= 6'h00;
      idx_q <= 5'h00;
      conv_mag_q <= 32'h0000_0000;
      conv_div_q <= 16'h0001;
      neg_q <= 1'b0;
      two_dec_q <= 1'b0;
      dot_q <= 1'b0;
      pos_q <= 4'h0;
      null_cnt_q <= 8'h00;
      host_data <= 8'h00;
      host_valid <= 1'b0;
      rec_byte_q <= 8'h00;
      rec_valid_q <= 1'b0;
    end else begin
      if (host_valid && host_ready) begin
        host_valid <= 1'b0;
      end
      if (rec_valid_q && uart_ready) begin
        rec_valid_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          idx_q <= 5'h00;
          if (start_rec) begin
            // Data only once gas is on and the link is locked or handshake select is nonzero
            kind_q <= (gas_en_q != 16'h0000 && (locked || hs_sel_q != 16'h0000)) ? KIND_DATA : KIND_NULL;
            lit_q <= {`CH_AMP, `CH_AMP, `CH_CR, 232'h0};
            lit_n_q <= 6'h03;
            after_q <= ST_ITEMS;
            state_q <= ST_LIT;
          end else if (start_host) begin
            kind_q <= KIND_HOST;
            lit_q <= {hdr, 8'h00};
            lit_n_q <= `HDR_LEN;
            conv_mag_q <= packet_number;
            conv_div_q <= 16'h0001;
            neg_q <= 1'b0;
            two_dec_q <= 1'b0;
            after_q <= ST_CONV;
            state_q <= ST_LIT;
          end
        end
        ST_LIT: begin
          if (free) begin
            if (kind_q == KIND_HOST) begin
              host_data <= lit_q[255:248];
              host_valid <= 1'b1;
            end else begin
              rec_byte_q <= lit_q[255:248];
              rec_valid_q <= 1'b1;
            end
            lit_q <= {lit_q[247:0], 8'h00};
            lit_n_q <= lit_n_q - 6'h01;
            if (lit_n_q == 6'h01) begin
              state_q <= after_q;
            end
          end
        end
        ST_ITEMS: begin
          if (idx_q >= item_cnt) begin
            if (kind_q == KIND_HOST) begin
              lit_q <= {`CH_CR, `CH_LF, 240'h0};
              lit_n_q <= 6'h02;
            end else begin
              lit_q <= {`CH_BANG, `CH_BANG, `CH_CR, 232'h0};
              lit_n_q <= 6'h03;
            end
            if (kind_q == KIND_NULL && !locked) begin
              null_cnt_q <= null_cnt_q + 8'h01;
            end
            after_q <= ST_IDLE;
            state_q <= ST_LIT;
          end else begin
            idx_q <= idx_q + 5'h01;
            if (it_ok) begin
              // Identifier digits straight before the value
              if (kind_q == KIND_HOST) begin
                lit_q <= {`CH_COMMA, `DIGIT_HI, it.id[15:12], `DIGIT_HI, it.id[11:8],
                  `DIGIT_HI, it.id[7:4], `DIGIT_HI, it.id[3:0], 216'h0};
                lit_n_q <= 6'h05;
              end else begin
                lit_q <= {`DIGIT_HI, it.id[15:12], `DIGIT_HI, it.id[11:8],
                  `DIGIT_HI, it.id[7:4], `DIGIT_HI, it.id[3:0], 224'h0};
                lit_n_q <= 6'h04;
              end
              neg_q <= it.value[31];
              conv_mag_q <= it.value[31] ? 32'(-it.value) : 32'(it.value);
              conv_div_q <= (it.divide && gas_div_q != 16'h0000) ? gas_div_q : 16'h0001;
              two_dec_q <= it.two_dec;
              after_q <= ST_CONV;
              state_q <= ST_LIT;
            end
          end
        end
        ST_CONV: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_valid && free) begin
            if (neg_q) begin
              if (kind_q == KIND_HOST) begin
                host_data <= `CH_MINUS;
                host_valid <= 1'b1;
              end else begin
                rec_byte_q <= `CH_MINUS;
                rec_valid_q <= 1'b1;
              end
            end
            pos_q <= start_pos;
            dot_q <= 1'b0;
            state_q <= ST_DIGITS;
          end
        end
        ST_DIGITS: begin
          if (free) begin
            if (two_dec_q && pos_q == 4'h1 && !dot_q) begin
              dot_q <= 1'b1;
              host_data <= `CH_DOT;
              rec_byte_q <= `CH_DOT;
            end else begin
              host_data <= {`DIGIT_HI, conv_bcd[4*pos_q +: 4]};
              rec_byte_q <= {`DIGIT_HI, conv_bcd[4*pos_q +: 4]};
              pos_q <= pos_q - 4'h1;
              if (pos_q == 4'h0) begin
                if (kind_q == KIND_HOST) begin
                  state_q <= ST_ITEMS;
                end else begin
                  lit_q <= {`CH_CR, 248'h0};
                  lit_n_q <= 6'h01;
                  after_q <= ST_ITEMS;
                  state_q <= ST_LIT;
                end
              end
            end
            host_valid <= (kind_q == KIND_HOST);
            rec_valid_q <= (kind_q != KIND_HOST);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter and serial line

  value_to_decimal u_conv (
    .core_clk(core_clk),
    .rst(rst),
    .start(state_q == ST_CONV),
    .dividend(conv_mag_q),
    .divisor(conv_div_q),
    .valid(conv_valid),
    .bcd(conv_bcd)
  );

  serial_tx #(
    .CLKS_PER_BIT(CLKS_PER_BIT)
  ) u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .tx_valid(rec_valid_q),
    .tx_byte(rec_byte_q),
    .tx_ready(uart_ready),
    .txd(txd)
  );

endmodule : wits_packet_framer

// ==== testbench/recorder_model.sv ====
// Serial receiver standing in for the drilling recorder
`timescale 1ns/1ps
module recorder_model #(parameter int unsigned CLKS_PER_BIT = 4) (
  input wire logic core_clk,
  input wire logic txd,
  output logic [7:0] rx_byte,
  output logic rx_strobe
);
  initial begin
    rx_strobe = 1'b0;
    forever begin
      @(negedge txd);
      repeat (CLKS_PER_BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (CLKS_PER_BIT) @(posedge core_clk);
        rx_byte[i] = txd;
      end
      repeat (CLKS_PER_BIT) @(posedge core_clk);
      rx_strobe = txd;
      @(posedge core_clk);
      rx_strobe = 1'b0;
    end
  end
endmodule : recorder_model

// ==== testbench/wits_framer_assertions.sv ====
// Port checker for the packet framer
`timescale 1ns/1ps
module wits_framer_assertions #(parameter int unsigned CLKS_PER_BIT = 4) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd,
  input wire logic host_send,
  input wire logic host_ready,
  input wire logic host_valid,
  input wire logic [7:0] host_data,
  input wire logic [15:0] rdata,
  input wire logic txd
);
  logic [7:0] last_q;
  int unsigned low_q, wait_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) last_q <= 8'h0A;
    else if (host_valid && host_ready) last_q <= host_data;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) low_q <= 0;
    else low_q <= txd ? 0 : low_q + 1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) wait_q <= 0;
    else wait_q <= (host_valid || (wait_q == 0 && !host_send)) ? 0 : wait_q + 1;
  end
  ////////////////////////////////////////
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("read data out of slot");
  a_host_hold: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
    else $error("host byte dropped");
  a_byte_gap: assert property (host_valid && host_ready |=> !host_valid) else $error("no byte gap");
  a_start_caret: assert property (host_valid && last_q == 8'h0A |-> host_data == 8'h5E)
    else $error("packet start wrong");
  a_lf_after_cr: assert property (host_valid && host_data == 8'h0A |-> last_q == 8'h0D) else $error("stray lf");
  a_cr_then_lf: assert property (host_valid && last_q == 8'h0D |-> host_data == 8'h0A) else $error("cr not ended");
  a_no_empty_field: assert property (host_valid && last_q == 8'h2C |-> host_data != 8'h2C && host_data != 8'h0D)
    else $error("empty field");
  a_low_run_len: assert property ($rose(txd) |-> low_q % CLKS_PER_BIT == 0) else $error("bit width");
  a_low_run_max: assert property (low_q <= 9 * CLKS_PER_BIT) else $error("missing stop bit");
  a_auto_start: assert property ($fell(rst) |-> ##[1:64] !txd) else $error("no frame after reset");
  a_host_answer: assert property (wait_q < 3000 * CLKS_PER_BIT) else $error("host stuck");
  cover property (host_valid && host_ready && host_data == 8'h0A);
  cover property ($rose(txd));
  cover property ($past(rd) && rdata != 16'h0000);
endmodule : wits_framer_assertions
bind wits_packet_framer wits_framer_assertions #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_chk (.core_clk(core_clk), .rst(rst),
  .rd(rd), .host_send(host_send), .host_ready(host_ready), .host_valid(host_valid), .host_data(host_data),
  .rdata(rdata), .txd(txd));

// ==== testbench/test_wits_packet_framer.sv ====
// Testbench for the packet framer
`timescale 1ns/1ps
module test_wits_packet_framer import wits_framer_pkg::*;;
  localparam int P = 8000;
  localparam string NUL = "&&\r0111-9999\r!!\r";
  logic core_clk, rst, wr, rd, pc_connected, host_send, host_ready, host_valid, txd, rx_strobe;
  logic [7:0] addr, host_data, rx_byte;
  logic [15:0] wdata, rdata;
  logic [31:0] packet_number;
  logic [63:0] job_id;
  meas_type meas;
  stamp_type stamp;
  item_type [7:0] host_items;
  int errors, samples_checked, cyc;
  byte hq[$];
  wits_packet_framer #(.PERIOD_CYCLES(P), .CLKS_PER_BIT(4), .LOCK_NULLS(3), .N_HOST(8)) dut (.core_clk(core_clk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .pc_connected(pc_connected),
    .host_send(host_send), .packet_number(packet_number), .job_id(job_id), .stamp(stamp), .host_items(host_items),
    .host_ready(host_ready), .host_data(host_data), .host_valid(host_valid), .txd(txd));
  recorder_model #(.CLKS_PER_BIT(4)) model (.core_clk(core_clk), .txd(txd), .rx_byte(rx_byte), .rx_strobe(rx_strobe));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    host_ready <= ~host_ready;
    if (host_valid === 1'b1 && host_ready === 1'b1) hq.push_back(host_data);
    if (cyc == 90000) begin
      errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wreg(logic [7:0] a, logic [15:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk); wr <= 1'b0;
    @(posedge core_clk);
  endtask : wreg
  task automatic rreg(logic [7:0] a, logic [15:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk); rd <= 1'b0;
    #1 chk("rdata", rdata, e);
    @(posedge core_clk);
  endtask : rreg
  task automatic rx_frame(output string f, output int t);
    f = "";
    do begin
      @(posedge rx_strobe);
      if (f.len() == 0) t = cyc;
      f = {f, string'(rx_byte)};
    end while (f.len() < 3 || f.substr(f.len() - 3, f.len() - 1) != "!!\r");
  endtask : rx_frame
  task automatic cmp(string f, string e);
    chk("length", f.len(), e.len());
    foreach (e[i]) chk("byte", f[i], e[i]);
  endtask : cmp
  function automatic string data(string tg, string c, bit pc);
    string s = {"&&\r0140", tg, "\r"};
    for (int i = 2; i <= 8; i++) s = {s, $sformatf("121%0d%s\r", i, c)};
    s = {s, "12220.00\r12250.00\r1826-0.05\r"};
    if (pc) s = {s, "0138280\r013914832\r"};
    return {s, "!!\r"};
  endfunction : data
  ////////////////////////////////////////
  task automatic t_regs_and_lock;
    string f;
    int t0, t1;
    rreg(8'h0C, 16'h0001);
    rreg(8'h43, 16'h0000);
    rreg(8'h44, 16'h0000);
    rreg(8'h46, 16'h00FF);
    rreg(8'h10, 16'h0000);
    rreg(8'h1A, 16'h0001);
    wreg(8'h1A, 16'h0002);
    rreg(8'h1A, 16'h0002);
    rx_frame(f, t0); cmp(f, NUL);
    rx_frame(f, t1); cmp(f, NUL);
    chk("period", t1 - t0 > P - 9 && t1 - t0 < P + 9, 1'b1);
    rx_frame(f, t1); cmp(f, NUL);
    rx_frame(f, t1); cmp(f, data("5.00", "0.00", 0));
    rreg(8'h47, 16'h0001);
    $display("test regs and lock done");
  endtask : t_regs_and_lock
  task automatic t_config;
    string f;
    int t;
    wreg(8'h0C, 16'h0000);
    rx_frame(f, t); cmp(f, NUL);
    wreg(8'h0C, 16'h0001);
    wreg(8'h44, 16'h0001);
    pc_connected <= 1'b1;
    rx_frame(f, t); cmp(f, data("1.50", "1.00", 1));
    $display("test config done");
  endtask : t_config
  task automatic t_host;
    string f = "";
    wreg(8'h46, 16'h0005);
    host_send <= 1'b1;
    @(posedge core_clk); host_send <= 1'b0;
    while (hq.size() == 0 || hq[hq.size() - 1] != 8'h0A) @(posedge core_clk);
    foreach (hq[i]) f = {f, string'(hq[i])};
    cmp(f, "^,JOB_0001,2024/05/06,07:08:09,123,01102000.40,0127-3\r\n");
    $display("test host done");
  endtask : t_host
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000; pc_connected = 1'b0;
    host_send = 1'b0; host_ready = 1'b0; packet_number = 32'h0000_007B; job_id = "JOB_0001";
    stamp = '{16'h2024, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
    host_items = '0; meas = '0; errors = 0; samples_checked = 0; cyc = 0;
    host_items[0] = '{16'h0110, 1'b1, 1'b0, 32'h0003_0D68};
    host_items[2] = '{16'h0127, 1'b0, 1'b0, 32'hFFFF_FFFD};
    meas.gas_units[0] = 32'h0000_03E9;
    meas.gas_ppm[0] = 32'h0000_012C;
    for (int i = 1; i < 8; i++) meas.gas_ppm[i] = 32'h0000_0064;
    meas.h2s = 32'hFFFF_FFFB;
    meas.lag_strokes = 32'h0000_0118;
    meas.lag_depth = 32'h0000_39F0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs_and_lock();
    t_config();
    t_host();
    tally_and_finish();
  end
endmodule : test_wits_packet_framer
